// [core/usb_wrapper_control_regs.sv]
/*
 * Wrapper control and status register bank around a USB controller core.
 * Holds soft reset, mode and per-endpoint settings and reports the VBUS
 * drive level. Assumes a single-cycle register port with read data one
 * cycle after the read strobe, and a VBUS drive pin from outside the
 * clock domain.
 */
//
// How it works
// - Writing one to control bit 0 starts a module reset; hardware clears it.
// - Control bit 4 enables encapsulation mode for every endpoint at once.
// - Control bit 3 zero selects dedicated interrupt path, one the alternate.
// - Control bit 1 enables fast acknowledge of clock-stop requests.
// - Status bit 0 reads the VBUS drive output level after a two-stage synchroniser.
// - Encap register bits 16-19 enable receive endpoints 1-4, reset zero.
// - Encap register bits 0-3 enable transmit endpoints 1-4, reset zero.
// - Auto-request register holds two bits per receive endpoint, reset zero.
// - Auto codes: 0 none, 1 all but final short, 3 always; 2 reserved.
`timescale 1ns/1ps

module usb_wrapper_control_regs (
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic [11:0] reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [31:0] reg_rdata,
    input  wire logic        vbus_drive_out,
    input  wire logic        clock_stop_req,
    output logic             clock_stop_ack,
    output logic             module_soft_rst,
    output logic             net_encap_mode,
    output logic             dedicated_irq_path,
    output logic             alt_irq_handler_sel,
    output logic             clock_stop_fast_ack,
    output logic      [3:0]  tx_ep_encap_en,
    output logic      [3:0]  rx_ep_encap_en,
    output logic      [7:0]  rx_auto_request,
    output logic      [3:0]  rx_auto_req_on,
    output logic      [3:0]  rx_auto_req_skip_eop
);

    ////////////////////////////////////////////////////////////////////////
    // Address decode.

    wire logic sel_ctrl    = (reg_addr == usb_wrap_regs_pkg::CTRL_OFFSET);
    wire logic sel_status  = (reg_addr == usb_wrap_regs_pkg::STATUS_OFFSET);
    wire logic sel_encap   = (reg_addr == usb_wrap_regs_pkg::ENCAP_OFFSET);
    wire logic sel_rx_auto_request = (reg_addr == usb_wrap_regs_pkg::RX_AUTO_REQUEST_OFFSET);

    wire logic wr_ctrl    = reg_write && sel_ctrl;
    wire logic wr_encap   = reg_write && sel_encap;
    wire logic wr_rx_auto_request = reg_write && sel_rx_auto_request;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers. The first stage feeds only the second.

    logic vbus_meta_reg;
    logic vbus_sync_reg;
    logic stop_meta_reg;
    logic stop_sync_reg;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            vbus_meta_reg <= 1'b0;
            vbus_sync_reg <= 1'b0;
            stop_meta_reg <= 1'b0;
            stop_sync_reg <= 1'b0;
        end else begin
            vbus_meta_reg <= vbus_drive_out;
            vbus_sync_reg <= vbus_meta_reg;
            stop_meta_reg <= clock_stop_req;
            stop_sync_reg <= stop_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control register.

    logic       encap_reg;
    logic       alt_irq_reg;
    logic       fack_reg;
    logic       srst_busy_reg;
    logic [3:0] srst_cnt_reg;

    wire logic srst_start =
        wr_ctrl && reg_wdata[usb_wrap_regs_pkg::CTRL_RESET_BIT];
    wire logic srst_done  =
        srst_busy_reg && (srst_cnt_reg == usb_wrap_regs_pkg::SRST_LAST);

    // A write of one during a running reset restarts the count, so the
    // module always sees a full-length reset after the last request.
    // The start edge loads the count with zero and the reset ends on the
    // edge after the count reaches its last value. The busy flag therefore
    // stands for exactly the configured number of cycles.
    // Limitation: the bank itself is not cleared by its own soft reset.
    // Software must rewrite the mode settings after one if it wants them
    // back at their reset values, because only the core behind the bank is
    // reset. This keeps the register port usable while the core restarts.
    wire logic       srst_busy_next = srst_start || (srst_busy_reg &&
                                                    !srst_done);
    wire logic [3:0] srst_cnt_next  =
        srst_start    ? usb_wrap_regs_pkg::SRST_ZERO :
        srst_busy_reg ? srst_cnt_reg + usb_wrap_regs_pkg::SRST_ONE :
                        usb_wrap_regs_pkg::SRST_ZERO;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            srst_busy_reg <= 1'b0;
            srst_cnt_reg  <= usb_wrap_regs_pkg::SRST_ZERO;
        end else begin
            srst_busy_reg <= srst_busy_next;
            srst_cnt_reg  <= srst_cnt_next;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            encap_reg   <= 1'b0;
            alt_irq_reg <= 1'b0;
            fack_reg    <= 1'b0;
        end else if (wr_ctrl) begin
            encap_reg   <= reg_wdata[usb_wrap_regs_pkg::CTRL_ENCAP_BIT];
            alt_irq_reg <= reg_wdata[usb_wrap_regs_pkg::CTRL_ALTIRQ_BIT];
            fack_reg    <= reg_wdata[usb_wrap_regs_pkg::CTRL_FACK_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Endpoint encapsulation enables and automatic request fields.

    logic [3:0] tx_en_reg;
    logic [3:0] rx_en_reg;
    logic [7:0] rx_auto_request_reg;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            tx_en_reg <= usb_wrap_regs_pkg::EP_RESET;
            rx_en_reg <= usb_wrap_regs_pkg::EP_RESET;
        end else if (wr_encap) begin
            tx_en_reg <= reg_wdata[usb_wrap_regs_pkg::ENCAP_TX_LSB +:
                                   usb_wrap_regs_pkg::EP_COUNT];
            rx_en_reg <= reg_wdata[usb_wrap_regs_pkg::ENCAP_RX_LSB +:
                                   usb_wrap_regs_pkg::EP_COUNT];
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            rx_auto_request_reg <= usb_wrap_regs_pkg::RX_AUTO_REQUEST_RESET;
        end else if (wr_rx_auto_request) begin
            rx_auto_request_reg <= reg_wdata[usb_wrap_regs_pkg::RX_AUTO_REQUEST_LSB +:
                                     usb_wrap_regs_pkg::RX_AUTO_REQUEST_BITS];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Decoded per-endpoint controls. The reserved code is kept out of the
    // decoded controls by treating it as no automatic request; the raw rx_auto_request output still carries it.

    logic [3:0] tx_eff_next;
    logic [3:0] rx_eff_next;
    logic [3:0] auto_on_next;
    logic [3:0] auto_skip_next;

    always_comb begin
        for (int i = 0; i < usb_wrap_regs_pkg::EP_COUNT; i++) begin
            tx_eff_next[i]    = tx_en_reg[i] || encap_reg;
            rx_eff_next[i]    = rx_en_reg[i] || encap_reg;
            case (usb_wrap_regs_pkg::auto_req_mode_t'(
                      rx_auto_request_reg[i*usb_wrap_regs_pkg::RX_AUTO_REQUEST_W +:
                                  usb_wrap_regs_pkg::RX_AUTO_REQUEST_W]))
                usb_wrap_regs_pkg::AUTO_REQ_NO_EOP: begin
                    auto_on_next[i]   = 1'b1;
                    auto_skip_next[i] = 1'b1;
                end
                usb_wrap_regs_pkg::AUTO_REQ_ALWAYS: begin
                    auto_on_next[i]   = 1'b1;
                    auto_skip_next[i] = 1'b0;
                end
                default: begin
                    auto_on_next[i]   = 1'b0;
                    auto_skip_next[i] = 1'b0;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data, one cycle after the strobe; reserved bits read zero.

    logic [31:0] ctrl_word;
    logic [31:0] status_word;
    logic [31:0] encap_word;
    logic [31:0] rx_auto_request_word;
    logic [31:0] rdata_next;

    always_comb begin
        ctrl_word    = usb_wrap_regs_pkg::ZERO_WORD;
        status_word  = usb_wrap_regs_pkg::ZERO_WORD;
        encap_word   = usb_wrap_regs_pkg::ZERO_WORD;
        rx_auto_request_word = usb_wrap_regs_pkg::ZERO_WORD;
        ctrl_word[usb_wrap_regs_pkg::CTRL_RESET_BIT]  = srst_busy_reg;
        ctrl_word[usb_wrap_regs_pkg::CTRL_FACK_BIT]   = fack_reg;
        ctrl_word[usb_wrap_regs_pkg::CTRL_ALTIRQ_BIT] = alt_irq_reg;
        ctrl_word[usb_wrap_regs_pkg::CTRL_ENCAP_BIT]  = encap_reg;
        status_word[usb_wrap_regs_pkg::STAT_VBUS_BIT] = vbus_sync_reg;
        encap_word[usb_wrap_regs_pkg::ENCAP_TX_LSB +:
                   usb_wrap_regs_pkg::EP_COUNT] = tx_en_reg;
        encap_word[usb_wrap_regs_pkg::ENCAP_RX_LSB +:
                   usb_wrap_regs_pkg::EP_COUNT] = rx_en_reg;
        rx_auto_request_word[usb_wrap_regs_pkg::RX_AUTO_REQUEST_LSB +:
                     usb_wrap_regs_pkg::RX_AUTO_REQUEST_BITS] = rx_auto_request_reg;
        if (!reg_read) begin
            rdata_next = usb_wrap_regs_pkg::ZERO_WORD;
        end else if (sel_ctrl) begin
            rdata_next = ctrl_word;
        end else if (sel_status) begin
            rdata_next = status_word;
        end else if (sel_encap) begin
            rdata_next = encap_word;
        end else if (sel_rx_auto_request) begin
            rdata_next = rx_auto_request_word;
        end else begin
            rdata_next = usb_wrap_regs_pkg::ZERO_WORD;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Registered outputs.

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata            <= usb_wrap_regs_pkg::ZERO_WORD;
            module_soft_rst      <= 1'b0;
            net_encap_mode       <= 1'b0;
            dedicated_irq_path   <= 1'b1;
            alt_irq_handler_sel  <= 1'b0;
            clock_stop_fast_ack  <= 1'b0;
            clock_stop_ack       <= 1'b0;
            tx_ep_encap_en       <= usb_wrap_regs_pkg::EP_RESET;
            rx_ep_encap_en       <= usb_wrap_regs_pkg::EP_RESET;
            rx_auto_request      <= usb_wrap_regs_pkg::RX_AUTO_REQUEST_RESET;
            rx_auto_req_on       <= usb_wrap_regs_pkg::EP_RESET;
            rx_auto_req_skip_eop <= usb_wrap_regs_pkg::EP_RESET;
        end else begin
            reg_rdata            <= rdata_next;
            module_soft_rst      <= srst_busy_next;
            net_encap_mode       <= encap_reg;
            dedicated_irq_path   <= !alt_irq_reg;
            alt_irq_handler_sel  <= alt_irq_reg;
            clock_stop_fast_ack  <= fack_reg;
            // Fast mode answers at once; otherwise the request is held
            // off until no soft reset is running.
            // Trade-off: the answer comes from the synchronised request,
            // so it lags the pin by up to three cycles even in fast mode.
            // A stop request that is withdrawn drops the answer the same
            // way, which keeps the handshake a plain level exchange.
            clock_stop_ack       <= stop_sync_reg &&
                                    (fack_reg || !srst_busy_reg);
            tx_ep_encap_en       <= tx_eff_next;
            rx_ep_encap_en       <= rx_eff_next;
            rx_auto_request      <= rx_auto_request_reg;
            rx_auto_req_on       <= auto_on_next;
            rx_auto_req_skip_eop <= auto_skip_next;
        end
    end

endmodule

// [core/usb_wrap_regs_pkg.sv]
/*
 * Constants for the wrapper control and status register bank: register
 * offsets, field positions, reset values, decode codes and timing.
 * Assumes a 32-bit plain register port with byte addresses.
 */
package usb_wrap_regs_pkg;

    localparam int          ADDR_W         = 12;
    localparam int          DATA_W         = 32;

    // Register byte offsets.
    localparam logic [11:0] CTRL_OFFSET    = 12'h000;
    localparam logic [11:0] STATUS_OFFSET  = 12'h004;
    localparam logic [11:0] ENCAP_OFFSET   = 12'h008;
    localparam logic [11:0] RX_AUTO_REQUEST_OFFSET = 12'h00C;

    // Control register fields.
    localparam int          CTRL_RESET_BIT  = 0;
    localparam int          CTRL_FACK_BIT   = 1;
    localparam int          CTRL_ALTIRQ_BIT = 3;
    localparam int          CTRL_ENCAP_BIT  = 4;

    // Status register field.
    localparam int          STAT_VBUS_BIT   = 0;

    // Encapsulation enable register fields.
    localparam int          ENCAP_TX_LSB    = 0;
    localparam int          ENCAP_RX_LSB    = 16;
    localparam int          EP_COUNT        = 4;

    // Automatic request register fields.
    localparam int          RX_AUTO_REQUEST_LSB     = 0;
    localparam int          RX_AUTO_REQUEST_W       = 2;
    localparam int          RX_AUTO_REQUEST_BITS    = 8;

    typedef enum logic [1:0] {
        AUTO_REQ_NONE   = 2'h0,
        AUTO_REQ_NO_EOP = 2'h1,
        AUTO_REQ_RSVD   = 2'h2,
        AUTO_REQ_ALWAYS = 2'h3
    } auto_req_mode_t;

    localparam logic [31:0] ZERO_WORD       = 32'h0000_0000;
    localparam logic [3:0]  EP_RESET        = 4'h0;
    localparam logic [7:0]  RX_AUTO_REQUEST_RESET   = 8'h00;

    // Length of the soft module reset pulse.
    localparam int          SOFT_RST_NS     = 64;
    localparam int          CLK_PERIOD_NS   = 8;
    localparam int          SOFT_RST_CYC    =
        (SOFT_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          SRST_CNT_W      = 4;
    localparam logic [3:0]  SRST_LAST       = 4'(SOFT_RST_CYC - 1);
    localparam logic [3:0]  SRST_ZERO       = 4'h0;
    localparam logic [3:0]  SRST_ONE        = 4'h1;

endpackage

// [sim/usb_wrap_regs_assertions.sv]
/* Checker for the wrapper control and status register bank.
   Assumes it is bound to the bank's top module and sees only its ports. */
`timescale 1ns/1ps

module usb_wrap_regs_chk (
    input wire logic        clock,
    input wire logic        sys_rst,
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_write,
    input wire logic        reg_read,
    input wire logic [31:0] reg_rdata,
    input wire logic        vbus_drive_out,
    input wire logic        module_soft_rst,
    input wire logic        net_encap_mode,
    input wire logic        dedicated_irq_path,
    input wire logic        alt_irq_handler_sel,
    input wire logic [3:0]  tx_ep_encap_en,
    input wire logic [3:0]  rx_ep_encap_en,
    input wire logic [7:0]  rx_auto_request,
    input wire logic [3:0]  rx_auto_req_on,
    input wire logic [3:0]  rx_auto_req_skip_eop
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    logic       ctrl_wr;
    logic       stat_rd;
    logic [7:0] r;
    assign ctrl_wr = reg_write && reg_addr == usb_wrap_regs_pkg::CTRL_OFFSET;
    assign stat_rd = reg_read && reg_addr == usb_wrap_regs_pkg::STATUS_OFFSET;
    assign r = rx_auto_request;

    ////////////////////////////////////////////////////////////////////////
    srst_start_a: assert property (ctrl_wr && reg_wdata[0] |=> module_soft_rst)
        else $error("soft reset did not start");
    // The count may be restarted by a rewrite, so only a floor of eight cycles and a loose ceiling are given.
    srst_length_a: assert property ($rose(module_soft_rst) |->
        module_soft_rst [*8] ##[0:40] !module_soft_rst)
        else $error("soft reset length wrong");
    srst_zero_a: assert property (ctrl_wr && !reg_wdata[0] && !module_soft_rst
        |=> !module_soft_rst) else $error("zero write started reset");
    irq_path_a: assert property (dedicated_irq_path != alt_irq_handler_sel)
        else $error("interrupt path selects disagree");
    encap_global_a: assert property (net_encap_mode |->
        tx_ep_encap_en == 4'hF && rx_ep_encap_en == 4'hF)
        else $error("global encapsulation not applied");
    auto_decode_a: assert property (rx_auto_req_on == {r[6], r[4], r[2], r[0]}
        && rx_auto_req_skip_eop == ({r[6], r[4], r[2], r[0]}
        & ~{r[7], r[5], r[3], r[1]})) else $error("auto request decode wrong");
    rdata_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
        else $error("read data not zero outside read");
    // The pin goes through a synchroniser, so only a settled level is judged.
    status_read_a: assert property (stat_rd && $stable(vbus_drive_out)
        && $past(vbus_drive_out) == $past(vbus_drive_out, 3)
        && $past(vbus_drive_out, 2) == $past(vbus_drive_out, 3)
        |=> reg_rdata == {31'h0, $past(vbus_drive_out)})
        else $error("status read wrong");
    cover property ($rose(module_soft_rst));
    cover property (stat_rd);
    cover property (net_encap_mode);
endmodule

bind usb_wrapper_control_regs usb_wrap_regs_chk i_usb_wrap_regs_chk (
    .clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .vbus_drive_out(vbus_drive_out),
    .module_soft_rst(module_soft_rst), .net_encap_mode(net_encap_mode),
    .dedicated_irq_path(dedicated_irq_path),
    .alt_irq_handler_sel(alt_irq_handler_sel),
    .tx_ep_encap_en(tx_ep_encap_en), .rx_ep_encap_en(rx_ep_encap_en),
    .rx_auto_request(rx_auto_request), .rx_auto_req_on(rx_auto_req_on),
    .rx_auto_req_skip_eop(rx_auto_req_skip_eop));

// [sim/usb_wrapper_control_regs_test.sv]
/* Self-checking bench for the wrapper register bank.
   Assumes the design's package and the bound checker are compiled first. */
`timescale 1ns/1ps

module usb_wrapper_control_regs_test;
    localparam logic [11:0] CTRL = usb_wrap_regs_pkg::CTRL_OFFSET;
    localparam logic [11:0] STAT = usb_wrap_regs_pkg::STATUS_OFFSET;
    localparam logic [11:0] ENC  = usb_wrap_regs_pkg::ENCAP_OFFSET;
    localparam logic [11:0] AREQ = usb_wrap_regs_pkg::RX_AUTO_REQUEST_OFFSET;
    logic        clock = 1'b0;
    logic        sys_rst = 1'b1;
    logic [11:0] reg_addr = 12'h000;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic        reg_write = 1'b0;
    logic        reg_read = 1'b0;
    logic        vbus_drive_out = 1'b0;
    logic        clock_stop_req = 1'b0;
    logic [31:0] reg_rdata;
    logic        clock_stop_ack, module_soft_rst, net_encap_mode;
    logic        dedicated_irq_path, alt_irq_handler_sel, clock_stop_fast_ack;
    logic [3:0]  tx_ep_encap_en, rx_ep_encap_en, rx_auto_req_on;
    logic [3:0]  rx_auto_req_skip_eop;
    logic [7:0]  rx_auto_request;
    int          failures = 0;
    int          checks_done = 0;
    logic [7:0]  aq_val [5] = '{8'h00, 8'h55, 8'hFF, 8'h74, 8'hCD};
    logic [3:0]  aq_on  [5] = '{4'h0, 4'hF, 4'hF, 4'hE, 4'hB};
    logic [3:0]  aq_skp [5] = '{4'h0, 4'hF, 4'h0, 4'hA, 4'h1};

    always #4 clock = ~clock;

    usb_wrapper_control_regs i_usb_wrapper_control_regs (
        .clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .vbus_drive_out(vbus_drive_out),
        .clock_stop_req(clock_stop_req), .clock_stop_ack(clock_stop_ack),
        .module_soft_rst(module_soft_rst), .net_encap_mode(net_encap_mode),
        .dedicated_irq_path(dedicated_irq_path),
        .alt_irq_handler_sel(alt_irq_handler_sel),
        .clock_stop_fast_ack(clock_stop_fast_ack),
        .tx_ep_encap_en(tx_ep_encap_en), .rx_ep_encap_en(rx_ep_encap_en),
        .rx_auto_request(rx_auto_request), .rx_auto_req_on(rx_auto_req_on),
        .rx_auto_req_skip_eop(rx_auto_req_skip_eop));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so look there.
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        #20000;
        failures++;
        tally_and_finish();
    end

    initial begin
        logic [31:0] d;
        repeat (20) @(posedge clock);
        sys_rst <= 1'b0;
        tick(1);
        // Offset 0x010 is unmapped and must read zero as well.
        for (int i = 0; i < 5; i++) rdc(12'(4 * i), 32'h0);
        chk(32'(dedicated_irq_path), 32'h1);
        wr(CTRL, 32'hFFFF_FFFE);
        rdc(CTRL, 32'h0000_001A);
        tick(2);
        chk(32'({net_encap_mode, alt_irq_handler_sel, dedicated_irq_path,
            clock_stop_fast_ack, tx_ep_encap_en, rx_ep_encap_en}), 32'hDFF);
        wr(CTRL, 32'h0000_0000);
        tick(2);
        chk(32'({net_encap_mode, alt_irq_handler_sel, dedicated_irq_path,
            clock_stop_fast_ack, tx_ep_encap_en, rx_ep_encap_en}), 32'h200);
        for (int i = 0; i < 4; i++) begin
            d = (32'h1 << (16 + i)) | (32'h1 << (3 - i)) | 32'hFFF0_FFF0;
            wr(ENC, d);
            rdc(ENC, d & 32'h000F_000F);
            tick(2);
            chk({24'h0, rx_ep_encap_en, tx_ep_encap_en},
                {24'h0, 4'(1 << i), 4'(8 >> i)});
        end
        for (int k = 0; k < 5; k++) begin
            wr(AREQ, {24'hFFFFFF, aq_val[k]});
            rdc(AREQ, {24'h0, aq_val[k]});
            tick(2);
            chk({16'h0, rx_auto_request, rx_auto_req_on, rx_auto_req_skip_eop},
                {16'h0, aq_val[k], aq_on[k], aq_skp[k]});
        end
        wr(STAT, 32'hFFFF_FFFF);
        vbus_drive_out <= 1'b1;
        tick(5);
        rdc(STAT, 32'h1);
        vbus_drive_out <= 1'b0;
        tick(5);
        rdc(STAT, 32'h0);
        clock_stop_req <= 1'b1;
        tick(5);
        chk(32'(clock_stop_ack), 32'h1);
        wr(CTRL, 32'h0000_0001);
        #1 chk(32'(module_soft_rst), 32'h1);
        rdc(CTRL, 32'h1);
        chk(32'(clock_stop_ack), 32'h0);
        tick(10);
        chk(32'(module_soft_rst), 32'h0);
        rdc(CTRL, 32'h0);
        wr(CTRL, 32'h0000_0003);
        tick(3);
        chk(32'({clock_stop_ack, module_soft_rst}), 32'h3);
        tick(10);
        wr(CTRL, 32'h0000_0000);
        tick(3);
        chk(32'(module_soft_rst), 32'h0);
        tally_and_finish();
    end
endmodule
